// ==== rtl/wakeup_timer.sv ====
// wakeup timer: 32-bit counter on a prescaled low-frequency source, periodic event
// assumes the three oscillators arrive as raw levels from other clock domains
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "wakeup_timer_params.svh"

module wakeup_timer
    import wakeup_timer_pkg::*;
#(
    parameter int COUNT_W = 32,
    parameter int PRESCALE_SELECT_W = 3
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [`WT_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic low_freq_rc_osc,
    input wire logic low_freq_crystal_osc,
    input wire logic ultra_low_freq_rc_osc,
    input wire logic debug_halt,
    output logic irq,
    output logic wakeup_event,
    output logic wake_request
);
    import wakeup_timer_pkg::*;

    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync_in;
    assign sync_in = {debug_halt, ultra_low_freq_rc_osc, low_freq_crystal_osc, low_freq_rc_osc};

    // each pin level sampled at one clk_sys edge is seen two cycles later; debug halt
    // comes from the core clock domain and takes the same path
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= sync_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic enable_q;
    logic debug_run_q;
    osc_select_t osc_sel_q;
    logic [PRESCALE_SELECT_W-1:0] prescale_select_q;
    logic [`WT_PERIOD_MSB:0] period_sel_q;
    logic deep_wake_en_q;
    logic flag_q;
    logic int_en_q;
    logic read_clear_q;
    logic [COUNT_W-1:0] count_q;

    function automatic logic hit(input logic [`WT_ADDR_W-1:0] a, input logic [`WT_ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    // fields land whole on a write; software changes them only while disabled
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_q <= 1'b0;
            debug_run_q <= 1'b0;
            osc_sel_q <= OSC_LOW_FREQ_RC;
            prescale_select_q <= `WT_PRESCALE_SELECT_RESET;
        end else if (reg_write && hit(reg_addr, `WT_OFS_CONTROL)) begin
            enable_q <= reg_wdata[`WT_BIT_ENABLE];
            debug_run_q <= reg_wdata[`WT_BIT_DEBUG_RUN];
            osc_sel_q <= osc_select_t'(reg_wdata[`WT_OSC_MSB:`WT_OSC_LSB]);
            prescale_select_q <= reg_wdata[`WT_PRESCALE_SELECT_MSB:`WT_PRESCALE_SELECT_LSB];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            period_sel_q <= `WT_PERIOD_RESET;
        end else if (reg_write && hit(reg_addr, `WT_OFS_PERIOD_SELECT)) begin
            period_sel_q <= reg_wdata[`WT_PERIOD_MSB:0];
        end
    end

    // one decode per access, shared by the state and the irq lookahead
    logic wr_int_enable;
    logic wr_flag_set;
    logic wr_flag_clear;
    logic rd_flag_clear;
    assign wr_int_enable = reg_write && hit(reg_addr, `WT_OFS_INT_ENABLE);
    assign wr_flag_set = reg_write && hit(reg_addr, `WT_OFS_FLAG_SET);
    assign wr_flag_clear = reg_write && hit(reg_addr, `WT_OFS_FLAG_CLEAR);
    assign rd_flag_clear = reg_read && hit(reg_addr, `WT_OFS_FLAG_CLEAR);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            deep_wake_en_q <= 1'b0;
        end else if (reg_write && hit(reg_addr, `WT_OFS_DEEP_SLEEP_WAKE)) begin
            deep_wake_en_q <= reg_wdata[`WT_BIT_DEEP_WAKE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            int_en_q <= 1'b0;
        end else if (wr_int_enable) begin
            int_en_q <= reg_wdata[`WT_BIT_PERIOD];
        end
    end

    // read-clear is off after reset, so a stray read cannot drop a pending wakeup
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            read_clear_q <= 1'b0;
        end else if (reg_write && hit(reg_addr, `WT_OFS_MISC)) begin
            read_clear_q <= reg_wdata[`WT_BIT_READ_CLEAR];
        end
    end

    // ---------------------------------------------------------------
    // counting clock: rising edge of the selected source
    // ---------------------------------------------------------------
    logic src_lvl;
    logic src_prev_q;
    logic src_rise;

    always_comb begin
        case (osc_sel_q)
            OSC_LOW_FREQ_RC: src_lvl = sync2_q[0];
            OSC_LOW_FREQ_CRYSTAL: src_lvl = sync2_q[1];
            OSC_ULTRA_LOW_FREQ_RC: src_lvl = sync2_q[2];
            default: src_lvl = 1'b0;
        endcase
    end

    // a change of source while enabled can fake an edge; reconfigure when disabled
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
        end
    end
    assign src_rise = src_lvl && !src_prev_q;

    // ---------------------------------------------------------------
    // run control and prescaler
    // ---------------------------------------------------------------
    // a one-cycle pulse at clk_sys stands for one counting-clock cycle, so
    // the half-cycle case at prescale 0, period 0 cannot be told apart
    run_state_t run_q;
    logic running;
    logic [6:0] prescale_select_cnt_q;
    logic [6:0] prescale_select_mask;
    logic tick;
    logic halted;

    assign halted = sync2_q[3] && !debug_run_q;

    // leaving idle straight into frozen keeps a tick from slipping in during a halt;
    // frozen also keeps the prescaler phase, so a halt loses no partial division
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !enable_q) begin
            run_q <= RUN_IDLE;
        end else begin
            case (run_q)
                RUN_IDLE: begin
                    if (halted) begin
                        run_q <= RUN_FROZEN;
                    end else begin
                        run_q <= RUN_COUNTING;
                    end
                end
                RUN_COUNTING: begin
                    if (halted) begin
                        run_q <= RUN_FROZEN;
                    end
                end
                RUN_FROZEN: begin
                    if (!halted) begin
                        run_q <= RUN_COUNTING;
                    end
                end
                default: run_q <= RUN_IDLE;
            endcase
        end
    end

    assign running = (run_q == RUN_COUNTING);
    assign prescale_select_mask = 7'((8'h01 << prescale_select_q) - 8'h01);

    // the prescaler phase clears with the count, so the first tick after
    // enable comes only after a full division
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !enable_q) begin
            prescale_select_cnt_q <= 7'h00;
        end else if (running && src_rise) begin
            prescale_select_cnt_q <= (prescale_select_cnt_q + 7'h01) & prescale_select_mask;
        end
    end
    assign tick = running && src_rise && ((prescale_select_cnt_q & prescale_select_mask) == prescale_select_mask);

    // ---------------------------------------------------------------
    // counter and period event
    // ---------------------------------------------------------------
    logic [COUNT_W-1:0] count_next;
    logic [COUNT_W:0] period_mask;
    logic period_hit;

    assign count_next = count_q + COUNT_W'(1);

    // the count restarts from zero on each enable, so a read gives ticks since enable
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !enable_q) begin
            count_q <= `WT_COUNT_RESET;
        end else if (tick) begin
            count_q <= count_next;
        end
    end

    // low N bits of the new count all zero; N = 32 means full wrap
    // select values 33 to 63 lie past the table and never fire
    assign period_mask = (COUNT_W+1)'((33'h1 << period_sel_q) - 33'h1);
    assign period_hit = tick && ((count_next & period_mask[COUNT_W-1:0]) == '0)
                        && (period_sel_q <= `WT_PERIOD_MAX);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wakeup_event <= 1'b0;
        end else begin
            wakeup_event <= period_hit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= period_hit && deep_wake_en_q;
        end
    end

    // ---------------------------------------------------------------
    // interrupt flag: hardware set beats software clear
    // ---------------------------------------------------------------
    logic flag_clr;
    logic flag_set;
    assign flag_set = period_hit
                      || (wr_flag_set && reg_wdata[`WT_BIT_PERIOD]);
    // a read-clear that meets a fresh event loses, so no wakeup is missed
    assign flag_clr = (wr_flag_clear && reg_wdata[`WT_BIT_PERIOD])
                      || (rd_flag_clear && read_clear_q);

    // the flag outlives enable going low; only reset, a clear or a read-clear drop it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else if (flag_set) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= flag_d_and_en(flag_set, flag_clr, flag_q) && int_en_next();
        end
    end

    // irq tracks the flag and enable as they stand after this edge
    function automatic logic flag_d_and_en(input logic s, input logic c, input logic q);
        flag_d_and_en = s || (q && !c);
    endfunction

    function automatic logic int_en_next();
        int_en_next = wr_int_enable ? reg_wdata[`WT_BIT_PERIOD] : int_en_q;
    endfunction

    // ---------------------------------------------------------------
    // read data, valid only in the cycle after the read strobe
    // ---------------------------------------------------------------
    // unmapped offsets and the write-only set register read as zero
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h00000000;
        case (reg_addr)
            `WT_OFS_CONTROL: begin
                rd_d[`WT_BIT_ENABLE] = enable_q;
                rd_d[`WT_BIT_DEBUG_RUN] = debug_run_q;
                rd_d[`WT_OSC_MSB:`WT_OSC_LSB] = osc_sel_q;
                rd_d[`WT_PRESCALE_SELECT_MSB:`WT_PRESCALE_SELECT_LSB] = prescale_select_q;
            end
            `WT_OFS_PERIOD_SELECT: rd_d[`WT_PERIOD_MSB:0] = period_sel_q;
            `WT_OFS_COUNT_VALUE: rd_d = count_q;
            `WT_OFS_DEEP_SLEEP_WAKE: rd_d[`WT_BIT_DEEP_WAKE] = deep_wake_en_q;
            `WT_OFS_FLAGS: rd_d[`WT_BIT_PERIOD] = flag_q;
            `WT_OFS_FLAG_CLEAR: rd_d[`WT_BIT_PERIOD] = read_clear_q && flag_q;
            `WT_OFS_INT_ENABLE: rd_d[`WT_BIT_PERIOD] = int_en_q;
            `WT_OFS_MISC: rd_d[`WT_BIT_READ_CLEAR] = read_clear_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// ==== rtl/wakeup_timer_params.svh ====
// register offsets, field positions, reset values and limits for the wakeup timer
// assumes inclusion by the design file, the checker and the bench
`ifndef WAKEUP_TIMER_PARAMS_SVH
`define WAKEUP_TIMER_PARAMS_SVH

`define WT_ADDR_W 8
`define WT_OFS_CONTROL 8'h00
`define WT_OFS_PERIOD_SELECT 8'h04
`define WT_OFS_COUNT_VALUE 8'h08
`define WT_OFS_DEEP_SLEEP_WAKE 8'h0C
`define WT_OFS_FLAGS 8'h10
`define WT_OFS_FLAG_SET 8'h14
`define WT_OFS_FLAG_CLEAR 8'h18
`define WT_OFS_INT_ENABLE 8'h1C
`define WT_OFS_MISC 8'h20

`define WT_BIT_ENABLE 0
`define WT_BIT_DEBUG_RUN 1
`define WT_OSC_LSB 2
`define WT_OSC_MSB 3
`define WT_PRESCALE_SELECT_LSB 5
`define WT_PRESCALE_SELECT_MSB 7
`define WT_BIT_PERIOD 0
`define WT_BIT_READ_CLEAR 0
`define WT_BIT_DEEP_WAKE 0

`define WT_PERIOD_MSB 5
`define WT_PERIOD_RESET 6'h20
`define WT_PERIOD_MAX 6'h20
`define WT_COUNT_RESET 32'h00000000
`define WT_OSC_RESET 2'h0
`define WT_PRESCALE_SELECT_RESET 3'h0

`endif

// ==== rtl/wakeup_timer_pkg.sv ====
// types shared by the wakeup timer design
// assumes the params header sits beside it
package wakeup_timer_pkg;
    typedef enum logic [1:0] {
        OSC_LOW_FREQ_RC = 2'b00,
        OSC_LOW_FREQ_CRYSTAL = 2'b01,
        OSC_ULTRA_LOW_FREQ_RC = 2'b10
    } osc_select_t;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_COUNTING = 2'b01,
        RUN_FROZEN = 2'b10
    } run_state_t;
endpackage

// ==== bench/wakeup_timer_properties.sv ====
// checker for the wakeup timer register port and event outputs
// assumes it is bound onto wakeup_timer, one clock domain
`timescale 1ns/100ps
`include "wakeup_timer_params.svh"
module wakeup_timer_properties #(
    parameter int COUNT_W = 32,
    parameter int PRESCALE_SELECT_W = 3
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [`WT_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic low_freq_rc_osc,
    input wire logic low_freq_crystal_osc,
    input wire logic ultra_low_freq_rc_osc,
    input wire logic debug_halt,
    input wire logic irq,
    input wire logic wakeup_event,
    input wire logic wake_request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // irq sources removed with no event nearby
    // ----------------------------------------
    // a fresh event would set the flag again, so the quiet window excludes it
    sequence s_quiet(logic [7:0] a, logic b);
        reg_write && reg_addr == a && reg_wdata[0] == b && !wakeup_event ##1 !wakeup_event;
    endsequence
    a_irq_clear: assert property (s_quiet(8'h18, 1'h1) |-> !irq)
        else $error("irq stayed high after flag clear");
    a_irq_disable: assert property (s_quiet(8'h1C, 1'h0) |-> !irq)
        else $error("irq stayed high after enable cleared");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_period_mask: assert property (reg_read && reg_addr == 8'h04 |=> reg_rdata[31:6] == 26'h0)
        else $error("period select reserved bits set");
    a_flags_mask: assert property (reg_read && reg_addr == 8'h10 |=> reg_rdata[31:1] == 31'h0)
        else $error("flag register reserved bits set");
    a_wake_mask: assert property (reg_read && reg_addr == 8'h0C |=> reg_rdata[31:1] == 31'h0)
        else $error("wake enable reserved bits set");
    a_event_single: assert property (wakeup_event |=> !wakeup_event)
        else $error("event pulse longer than one cycle");
    a_wake_with_event: assert property (wake_request |-> wakeup_event)
        else $error("wake request without event");
endmodule

bind wakeup_timer wakeup_timer_properties #(.COUNT_W(COUNT_W), .PRESCALE_SELECT_W(PRESCALE_SELECT_W)) i_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .low_freq_rc_osc(low_freq_rc_osc), .low_freq_crystal_osc(low_freq_crystal_osc),
    .ultra_low_freq_rc_osc(ultra_low_freq_rc_osc), .debug_halt(debug_halt), .irq(irq),
    .wakeup_event(wakeup_event), .wake_request(wake_request));

// ==== bench/low_energy_wakeup_timer_tb.sv ====
// register-level bench for the wakeup timer
// assumes oscillators are slow square pulses made here, far below clk_sys
`timescale 1ns/100ps
`include "wakeup_timer_params.svh"
module low_energy_wakeup_timer_tb;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic [`WT_ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'h0;
    logic reg_read = 1'h0;
    logic [2:0] osc = 3'h0;
    logic debug_halt = 1'h0;
    logic [31:0] reg_rdata;
    logic irq;
    logic wakeup_event;
    logic wake_request;
    int n_fail = 0;
    int checks = 0;
    int ev_n = 0;
    int wr_n = 0;
    int ev0 = 0;
    int wr0 = 0;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h24};
    logic [31:0] rx [7] = '{32'h0, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    always #2 clk_sys = ~clk_sys;
    wakeup_timer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .low_freq_rc_osc(osc[0]), .low_freq_crystal_osc(osc[1]),
        .ultra_low_freq_rc_osc(osc[2]), .debug_halt(debug_halt), .irq(irq),
        .wakeup_event(wakeup_event), .wake_request(wake_request));
    always @(posedge clk_sys) begin
        if (wakeup_event === 1'h1) ev_n++;
        if (wake_request === 1'h1) wr_n++;
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk_sys);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk_sys);
        reg_read <= 1'h0;
        #1;
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    // each pulse stays high for 4 clocks so the synchroniser and event both land inside it
    task automatic pulses(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            osc[sel] <= 1'h1;
            repeat (4) @(posedge clk_sys);
            osc[sel] <= 1'h0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    function automatic logic [31:0] ctl(logic en, logic dbg, logic [1:0] sel, logic [2:0] p);
        return {24'h0, p, 1'h0, sel, dbg, en};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'h0;
        foreach (ra[i]) rd(ra[i], rx[i]);
        wr(8'h04, 32'h0000003F);
        rd(8'h04, 32'h3F);
        wr(8'h08, 32'h1234);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h0);
        for (int s = 0; s < 3; s++) begin
            ev0 = ev_n;
            wr(8'h00, ctl(1'h1, 1'h0, s[1:0], 3'h0));
            pulses((s + 1) % 3, 2);
            pulses(s, 3);
            rd(8'h08, 32'h3);
            check("events", ev_n - ev0, 3);
            wr(8'h00, 32'h0);
            rd(8'h08, 32'h0);
        end
        wr(8'h04, 32'h2);
        wr(8'h0C, 32'h1);
        wr(8'h00, ctl(1'h1, 1'h0, 2'h0, 3'h1));
        ev0 = ev_n;
        wr0 = wr_n;
        pulses(0, 16);
        rd(8'h08, 32'h8);
        check("events", ev_n - ev0, 2);
        check("wakes", wr_n - wr0, 2);
        wr(8'h0C, 32'h0);
        pulses(0, 8);
        check("events", ev_n - ev0, 3);
        check("wakes", wr_n - wr0, 2);
        rd(8'h10, 32'h1);
        wr(8'h18, 32'h1);
        rd(8'h10, 32'h0);
        wr(8'h1C, 32'h1);
        rd(8'h1C, 32'h1);
        check("irq", irq, 32'h0);
        wr(8'h14, 32'h1);
        rd(8'h10, 32'h1);
        check("irq", irq, 32'h1);
        wr(8'h1C, 32'h0);
        rd(8'h18, 32'h0);
        check("irq", irq, 32'h0);
        wr(8'h1C, 32'h1);
        wr(8'h18, 32'h0);
        rd(8'h10, 32'h1);
        wr(8'h18, 32'h1);
        rd(8'h10, 32'h0);
        check("irq", irq, 32'h0);
        wr(8'h20, 32'h1);
        wr(8'h14, 32'h1);
        rd(8'h18, 32'h1);
        rd(8'h10, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h00, ctl(1'h1, 1'h0, 2'h0, 3'h0));
        debug_halt <= 1'h1;
        repeat (4) @(posedge clk_sys);
        pulses(0, 2);
        rd(8'h08, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h00, ctl(1'h1, 1'h1, 2'h0, 3'h0));
        pulses(0, 2);
        rd(8'h08, 32'h2);
        @(posedge clk_sys);
        debug_halt <= 1'h0;
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'h0;
        rd(8'h04, 32'h20);
        rd(8'h10, 32'h0);
        check("irq", irq, 32'h0);
        tally_and_finish();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end
endmodule
